// ### test/tcss_mem_model.sv
// Main storage model answering the clock's doubleword requests.
`timescale 1ns/1ps
module tcss_mem_model
(
  // Clock.
  input wire logic clk,
  // Request side.
  input wire logic req,
  input wire logic we,
  input wire logic [63:0] wdata,
  input wire logic [63:0] rd_val,
  // Answer side.
  output logic ack,
  output logic [63:0] rdata,
  output logic [63:0] seen
);
  int wait_n = 2; // Cycles still to wait before the answer.

  // Answer after a random wait; outside the answer the read bus
  // toggles so that stale data can never look valid.
  initial ack = 1'b0;
  initial rdata = 64'h0;
  always @(posedge clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack)
    begin
      if (wait_n == 0)
      begin
        ack <= 1'b1;
        if (we)
          seen <= wdata;
        else
          rdata <= rd_val;
        wait_n = $urandom_range(0, 3);
      end
      else
        wait_n--;
    end
  end
endmodule

// ### test/tcss_top_sva.sv
// Assertion checker for the clock instruction and word ports.
`timescale 1ns/1ps
module tcss_top_sva
(
  // Clock, reset and enable.
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  // Requests.
  input wire logic [7:0] INSTR_OPCODE,
  input wire logic [7:0] INSTR_MODIFIER,
  input wire logic [23:0] INSTR_ADDR,
  input wire logic PROBLEM_STATE,
  input wire logic [4:0] CPU_ID,
  input wire logic EXT_RD,
  // Answers.
  input wire logic INSTR_DONE,
  input wire logic [1:0] INSTR_CC,
  input wire logic PRIV_CHECK,
  input wire logic SPEC_CHECK,
  input wire logic OPER_CHECK,
  input wire logic EXT_RVALID,
  input wire logic CLOCK_INVALID,
  // Storage port.
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic MEM_ACK,
  input wire logic [63:0] MEM_WDATA
);
  // A frozen clock enable stalls every sequence, so attempts under way are abandoned.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET || !CE);

  // ************************************************************
  // Checks and their causes
  // ************************************************************
  chk_done_a: assert property (
    (PRIV_CHECK || SPEC_CHECK || OPER_CHECK) |-> INSTR_DONE)
    else $error("check without done");
  spec_addr_a: assert property (
    SPEC_CHECK |-> ($past(INSTR_ADDR) & 24'h000007) != 24'h000000)
    else $error("spec check on aligned address");
  priv_set_a: assert property (
    PRIV_CHECK |-> $past(PROBLEM_STATE) &&
    $past(INSTR_MODIFIER) == 8'h04)
    else $error("priv check without cause");
  oper_bad_a: assert property (
    OPER_CHECK |-> $past(INSTR_OPCODE) != 8'hB2 ||
    !($past(INSTR_MODIFIER) inside {8'h04, 8'h05}))
    else $error("oper check on valid code");
  cc_range_a: assert property (
    INSTR_DONE && !(PRIV_CHECK || SPEC_CHECK || OPER_CHECK) |->
    INSTR_CC != 2'h3)
    else $error("condition code 3 given");

  // ************************************************************
  // Storage sequences and word reads
  // ************************************************************
  req_hold_a: assert property (
    MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_WDATA))
    else $error("storage request dropped");
  store_end_a: assert property (
    MEM_REQ && MEM_WE && MEM_ACK |=> INSTR_DONE && !MEM_REQ)
    else $error("store not ended after ack");
  // Secure ends three cycles after the fetch answer (stop, sense);
  // enabled ends five cycles after it (stop, sense, high, low).
  set_seq_a: assert property (
    MEM_REQ && !MEM_WE && MEM_ACK |=> !INSTR_DONE [*2] ##1
    ((INSTR_DONE && INSTR_CC == 2'h1) or
    (!INSTR_DONE [*2] ##1
    (INSTR_DONE && INSTR_CC == 2'h0 && !CLOCK_INVALID))))
    else $error("set sequence timing wrong");
  store_image_a: assert property (
    MEM_REQ && MEM_WE |-> MEM_WDATA[11:8] == 4'h0 &&
    ((MEM_WDATA == 64'h0) == (INSTR_CC != 2'h0)) &&
    (MEM_WDATA == 64'h0 || MEM_WDATA[4:0] == CPU_ID))
    else $error("store image malformed");
  read_ans_a: assert property (EXT_RD |=> EXT_RVALID)
    else $error("word read not answered");
endmodule

bind tcss_top tcss_top_sva u_sva
(
  .REF_CLK(REF_CLK), .RESET(RESET), .CE(CE),
  .INSTR_OPCODE(INSTR_OPCODE), .INSTR_MODIFIER(INSTR_MODIFIER),
  .INSTR_ADDR(INSTR_ADDR), .PROBLEM_STATE(PROBLEM_STATE),
  .CPU_ID(CPU_ID), .EXT_RD(EXT_RD), .INSTR_DONE(INSTR_DONE),
  .INSTR_CC(INSTR_CC), .PRIV_CHECK(PRIV_CHECK),
  .SPEC_CHECK(SPEC_CHECK), .OPER_CHECK(OPER_CHECK),
  .EXT_RVALID(EXT_RVALID), .CLOCK_INVALID(CLOCK_INVALID),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ACK(MEM_ACK),
  .MEM_WDATA(MEM_WDATA)
);

// ### test/tcss_top_tb.sv
// Self-checking bench for the clock instructions and clock words.
`timescale 1ns/1ps
module tcss_top_tb;
  logic clk, rst, ce, tick, cerr, key, iv, prob, ewr, erd, eb;
  logic done, pchk, schk, ochk, mreq, mwe, mack, rvld, inval;
  logic [4:0] id;
  logic [7:0] iop, imd, ead;
  logic [23:0] iad, madr, a;
  logic [1:0] cc;
  logic [31:0] ewd, erdat;
  logic [63:0] rdv, d, mwd, mrd, seen;
  int num_errors, comparisons, n;

  // ************************************************************
  // Clock, design and storage
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  tcss_top DUT (.REF_CLK(clk), .RESET(rst), .CE(ce),
    .TICK_1MHZ(tick), .CLOCK_ERROR(cerr), .KEY_ENABLE_SET(key),
    .CPU_ID(id), .INSTR_VALID(iv), .INSTR_OPCODE(iop),
    .INSTR_MODIFIER(imd), .INSTR_ADDR(iad), .PROBLEM_STATE(prob),
    .INSTR_DONE(done), .INSTR_CC(cc), .PRIV_CHECK(pchk),
    .SPEC_CHECK(schk), .OPER_CHECK(ochk), .MEM_REQ(mreq),
    .MEM_WE(mwe), .MEM_ADDR(madr), .MEM_WDATA(mwd), .MEM_ACK(mack),
    .MEM_RDATA(mrd), .EXT_WR(ewr), .EXT_RD(erd), .EXT_BYTE_MODE(eb),
    .EXT_ADDR(ead), .EXT_WDATA(ewd), .EXT_RDATA(erdat),
    .EXT_RVALID(rvld), .CLOCK_INVALID(inval));
  tcss_mem_model u_mem (.clk(clk), .req(mreq), .we(mwe),
    .wdata(mwd), .rd_val(rdv), .ack(mack), .rdata(mrd), .seen(seen));

  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  // Compare and count; an unknown never passes.
  task chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // The idle sequencer takes the request at the first edge, so it is
  // dropped there; held until done it would be taken a second time.
  task instr(input logic [7:0] op, input logic [7:0] md,
    input logic [23:0] ad, input logic [1:0] ecc, input logic [2:0] ef);
    int k;
    @(posedge clk);
    iv <= 1'b1;
    iop <= op;
    imd <= md;
    iad <= ad;
    @(posedge clk);
    iv <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 60);
    chk(done, 1'b1);
    chk({pchk, schk, ochk}, ef);
    if (ef == 3'h0)
      chk(cc, ecc);
  endtask

  // Write one clock word, whole or as a repeated byte.
  task word_wr(input logic [7:0] ad, input logic [31:0] w, input logic b);
    @(posedge clk);
    ewr <= 1'b1;
    ead <= ad;
    ewd <= w;
    eb <= b;
    @(posedge clk);
    ewr <= 1'b0;
  endtask

  // Read one clock word and compare it.
  task word_rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    erd <= 1'b1;
    ead <= ad;
    @(posedge clk);
    erd <= 1'b0;
    @(negedge clk);
    chk(rvld, 1'b1);
    chk(erdat, e);
  endtask

  task pulse_tick;
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask

  // Expected low word: counter bits, spare zeros, controls, identity.
  function logic [31:0] lo(input logic [19:0] c, input logic [2:0] f);
    return {c, 4'h0, f, id};
  endfunction

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run the normal way.
  initial
  begin
    repeat (6000) @(posedge clk);
    num_errors++;
    test_done;
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    void'($urandom(32'hFDFECA42));
    {rst, ce, tick, cerr, key, iv, prob, ewr, erd, eb} = 10'h300;
    {iop, imd, ead, iad, ewd, rdv} = 144'h0;
    id = 5'($urandom);
    num_errors = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    word_rd(8'h36, 32'h0);
    word_rd(8'h3E, lo(20'h0, 3'h4));
    instr(8'hB2, 8'h05, 24'($urandom), 2'h1, 3'h0);
    chk(seen, 64'h0);
    $display("test reset done");
    n = $urandom_range(3, 20);
    repeat (n) pulse_tick;
    // A tick while the enable is low must not advance the counter.
    @(posedge clk) ce <= 1'b0;
    pulse_tick;
    @(posedge clk) ce <= 1'b1;
    word_rd(8'h3E, lo(20'(n), 3'h4));
    $display("test count done");
    for (int i = 0; i < 16; i++)
      if (i != 4 && i != 5)
        instr(8'hB2, 8'(i), 24'h0, 2'h0, 3'h1);
    instr(8'hB2, {4'(1 + $urandom_range(0, 14)), 4'h4}, 24'h0, 2'h0, 3'h1);
    instr(8'($urandom_range(0, 177)), 8'h05, 24'h0, 2'h0, 3'h1);
    @(posedge clk) prob <= 1'b1;
    instr(8'hB2, 8'h04, 24'h0, 2'h0, 3'h4);
    instr(8'hB2, 8'h05, 24'h3, 2'h1, 3'h0);
    @(posedge clk) prob <= 1'b0;
    instr(8'hB2, 8'h04, 24'($urandom_range(1, 7)), 2'h0, 3'h2);
    $display("test decode done");
    d = {$urandom, $urandom};
    rdv = d;
    a = 24'($urandom) & 24'hFFFFF8;
    instr(8'hB2, 8'h04, a, 2'h1, 3'h0);
    word_rd(8'h36, 32'h0);
    @(posedge clk) key <= 1'b1;
    instr(8'hB2, 8'h04, a, 2'h0, 3'h0);
    chk(madr, a);
    word_rd(8'h36, d[63:32]);
    word_rd(8'h3E, lo(d[31:12], 3'h6));
    chk(inval, 1'b0);
    pulse_tick;
    instr(8'hB2, 8'h05, 24'($urandom), 2'h0, 3'h0);
    chk(seen, {d[63:12] + 52'h1, 4'h0, 3'h6, id});
    $display("test set done");
    word_wr(8'h3E, 32'h0, 1'b1);
    word_wr(8'h3E, 32'h12, 1'b1);
    word_rd(8'h3E, lo(20'h12121, 3'h0));
    word_wr(8'h36, 32'hFF, 1'b1);
    word_wr(8'h3E, 32'hFFFFF080, 1'b0);
    word_rd(8'h36, 32'hFFFFFFFF);
    pulse_tick;
    word_rd(8'h36, 32'h0);
    word_rd(8'h3E, lo(20'h0, 3'h6));
    $display("test manual done");
    @(posedge clk) cerr <= 1'b1;
    @(posedge clk) cerr <= 1'b0;
    instr(8'hB2, 8'h05, 24'($urandom), 2'h2, 3'h0);
    chk(seen, 64'h0);
    chk(inval, 1'b1);
    $display("test error done");
    test_done;
  end
endmodule

// ### verilog/tcss_pkg.sv
// Constants, decode table, state encoding and state record of the clock.
package tcss_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W = 52; // Counter bits, instruction bits 0 to 51.
  localparam int WORD_W = 32; // One clock word.
  localparam int LO_CNT_W = 20; // Counter bits kept in the low word.
  localparam int ADDR_W = 24; // Main storage byte address.
  localparam int DW_W = 64; // One storage doubleword.
  localparam int ID_W = 5; // Processor identification field.

  // ****************************************************************
  // Word layout and addresses
  // ****************************************************************
  localparam logic [7:0] EXT_HI_ADDR = 8'h36; // External of the high word.
  localparam logic [7:0] EXT_LO_ADDR = 8'h3E; // External of the low word.
  localparam int LO_CNT_LSB = 12; // Low counter bits sit in 31..12.
  localparam int LO_RUN_BIT = 7; // Control byte bit 0: clock running.
  localparam int LO_SET_BIT = 6; // Control byte bit 1: clock was set.
  localparam int LO_ERR_BIT = 5; // Control byte bit 2: error occurred.
  localparam logic [3:0] SPARE_ZERO = 4'h0; // Spare positions 52-55.
  localparam logic [7:0] CTRL_CLEAR = 8'h00; // Cleared control byte.
  localparam logic [CNT_W-1:0] CNT_ONE = 52'h0000000000001; // Step.
  localparam logic [CNT_W-1:0] CNT_RESET = 52'h0000000000000;
  localparam logic [DW_W-1:0] DW_ZERO = 64'h0000000000000000;
  localparam logic [2:0] DW_ALIGN = 3'h0; // Low address bits on a boundary.

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  localparam logic [7:0] OPC_CLOCK = 8'hB2; // First opcode byte.
  localparam logic [3:0] MOD_UPPER = 4'h0; // Required upper modifier nibble.
  localparam logic [3:0] FN_SET = 4'h4; // Set-clock function.
  localparam logic [3:0] FN_STORE = 4'h5; // Store-clock function.
  localparam int DEC_PRIV_BIT = 7; // Decode byte: privileged.
  localparam int DEC_IMPL_BIT = 6; // Decode byte: function present.
  // Sixteen decode bytes, entry 15 first; low nibble is the routine.
  localparam logic [15:0][7:0] DEC_TABLE = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h45, 8'hC4, 8'h00, 8'h00, 8'h00, 8'h00};

  // ****************************************************************
  // Condition codes
  // ****************************************************************
  localparam logic [1:0] CC_0 = 2'h0;
  localparam logic [1:0] CC_1 = 2'h1;
  localparam logic [1:0] CC_2 = 2'h2;

  // ****************************************************************
  // Sequencer states and state record
  // ****************************************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_FETCH = 8'h02,
    ST_CLRRUN = 8'h04,
    ST_SENSE = 8'h08,
    ST_LOADH = 8'h10,
    ST_LOADL = 8'h20,
    ST_STORE = 8'h40,
    ST_SPARE = 8'h80
  } tcss_state_t;

  typedef struct packed {
    tcss_state_t st;
    logic [CNT_W-1:0] cnt;
    logic run;
    logic set;
    logic err;
    logic hi_loaded;
    logic secure;
    logic [WORD_W-1:0] hi_buf;
    logic [WORD_W-1:0] lo_buf;
    logic done;
    logic [1:0] cc;
    logic priv_chk;
    logic spec_chk;
    logic oper_chk;
    logic mem_req;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DW_W-1:0] mem_wdata;
    logic [WORD_W-1:0] ext_rdata;
    logic ext_rvalid;
    logic invalid;
  } tcss_regs_t;

endpackage

// ### verilog/tcss_top.sv
// Time-of-day clock counter, external words and clock instructions.
`timescale 1ns/1ps

// ******************************************************************
// Notes on behaviour
// ******************************************************************
// Notes on behaviour
// [RL1] High word bit 31 toggles about each second.
// [RL2] Single switch byte fills all four bytes.
// [RL3] Counter wraps from all ones to zero.
// [RL4] Second opcode byte is a function modifier.
// [RL5] Upper nibble zero; low nibble indexes table.
// [RL6] Privileged outside supervisor raises check, else dispatch.
// [RL7] Modifier 04 is privileged set clock.
// [RL8] Set clock operand must be doubleword aligned.
// [RL9] Only top 52 operand bits load counter.
// [RL10] Enable-set loads, code 0; secure, code 1.
// [RL11] Clear control byte, write low, stop clock.
// [RL12] Read back run bit to sense the switch.
// [RL13] Set run bit, high then low, start.
// [RL14] Modifier 05 stores clock at any address.
// [RL15] Store count, zeros, controls, processor identity.
// [RL16] Invalid clock stores an all-zero doubleword.
// [RL17] Store codes: set 0, not set 1, error 2.
// [RL18] Control bits: running, was set, error.
// [RL19] Bit 51 counts each accepted advance pulse.

module tcss_top
(
  // Clock, reset and clock enable.
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  // Clock hardware inputs.
  input wire logic TICK_1MHZ,
  input wire logic CLOCK_ERROR,
  input wire logic KEY_ENABLE_SET,
  input wire logic [tcss_pkg::ID_W-1:0] CPU_ID,
  // Instruction request from the microcode flow.
  input wire logic INSTR_VALID,
  input wire logic [7:0] INSTR_OPCODE,
  input wire logic [7:0] INSTR_MODIFIER,
  input wire logic [tcss_pkg::ADDR_W-1:0] INSTR_ADDR,
  input wire logic PROBLEM_STATE,
  // Instruction answer.
  output logic INSTR_DONE,
  output logic [1:0] INSTR_CC,
  output logic PRIV_CHECK,
  output logic SPEC_CHECK,
  output logic OPER_CHECK,
  // Main storage port.
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [tcss_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [tcss_pkg::DW_W-1:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [tcss_pkg::DW_W-1:0] MEM_RDATA,
  // Externally addressed clock words.
  input wire logic EXT_WR,
  input wire logic EXT_RD,
  input wire logic EXT_BYTE_MODE,
  input wire logic [7:0] EXT_ADDR,
  input wire logic [tcss_pkg::WORD_W-1:0] EXT_WDATA,
  output logic [tcss_pkg::WORD_W-1:0] EXT_RDATA,
  output logic EXT_RVALID,
  // Console indicator.
  output logic CLOCK_INVALID
);

  // ****************************************************************
  // State record
  // ****************************************************************
  tcss_pkg::tcss_regs_t r_q; // Registered state.
  tcss_pkg::tcss_regs_t r_d; // Next state.

  // Working values of the combinational process.
  logic wr_hi; // A destination of the high word this cycle.
  logic wr_lo; // A destination of the low word this cycle.
  logic [tcss_pkg::WORD_W-1:0] wdata; // Word being destined.
  logic [7:0] dec; // Selected decode byte.
  logic valid_now; // Clock value is a true time of day.
  logic [tcss_pkg::WORD_W-1:0] lo_word; // Low word as read out.
  logic [tcss_pkg::DW_W-1:0] dw_out; // Doubleword for store clock.

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // All behaviour lives in this one process so that the counter, the
  // control latches and the sequencer always see a single consistent
  // view of the previous cycle.
  always_comb
  begin
    r_d = r_q;
    wr_hi = 1'b0;
    wr_lo = 1'b0;
    wdata = '0;
    dec = tcss_pkg::DEC_TABLE[INSTR_MODIFIER[3:0]]; // RL5
    valid_now = r_q.run & r_q.set & ~r_q.err;
    // Low word readout: counter, forced spare zeros, controls, identity.
    lo_word = {r_q.cnt[tcss_pkg::LO_CNT_W-1:0], tcss_pkg::SPARE_ZERO,
      r_q.run, r_q.set, r_q.err, CPU_ID}; // RL18
    // The store image puts the whole count above the low control byte.
    dw_out = {r_q.cnt, tcss_pkg::SPARE_ZERO, r_q.run, r_q.set, r_q.err,
      CPU_ID}; // RL15
    // Answer strobes last a single cycle.
    r_d.done = 1'b0;
    r_d.priv_chk = 1'b0;
    r_d.spec_chk = 1'b0;
    r_d.oper_chk = 1'b0;
    r_d.ext_rvalid = 1'b0;

    // Sequencer.
    unique case (r_q.st)
      tcss_pkg::ST_IDLE:
      begin
        if (INSTR_VALID)
        begin
          // The modifier is a function code, never an operand. RL4
          if ((INSTR_OPCODE != tcss_pkg::OPC_CLOCK) ||
              (INSTR_MODIFIER[7:4] != tcss_pkg::MOD_UPPER) ||
              !dec[tcss_pkg::DEC_IMPL_BIT])
          begin
            // Not a clock function: report an operation check. RL5
            r_d.oper_chk = 1'b1;
            r_d.done = 1'b1;
          end
          else if (dec[tcss_pkg::DEC_PRIV_BIT] && PROBLEM_STATE)
          begin
            // Privileged function outside supervisor state. RL6
            r_d.priv_chk = 1'b1;
            r_d.done = 1'b1;
          end
          else if (dec[3:0] == tcss_pkg::FN_SET)
          begin
            // Set clock: the eight-byte operand must be aligned. RL7
            if (INSTR_ADDR[2:0] != tcss_pkg::DW_ALIGN)
            begin
              r_d.spec_chk = 1'b1; // RL8
              r_d.done = 1'b1;
            end
            else
            begin
              r_d.mem_req = 1'b1;
              r_d.mem_we = 1'b0;
              r_d.mem_addr = INSTR_ADDR;
              r_d.st = tcss_pkg::ST_FETCH;
            end
          end
          else
          begin
            // Store clock: any byte address is taken as it is. RL14
            r_d.mem_req = 1'b1;
            r_d.mem_we = 1'b1;
            r_d.mem_addr = INSTR_ADDR;
            // An invalid clock is stored as zeros. RL16
            r_d.mem_wdata = valid_now ? dw_out : tcss_pkg::DW_ZERO;
            // Error outranks not-set; set state gives code 0. RL17
            if (r_q.err)
              r_d.cc = tcss_pkg::CC_2;
            else if (r_q.run && r_q.set)
              r_d.cc = tcss_pkg::CC_0;
            else
              r_d.cc = tcss_pkg::CC_1;
            r_d.st = tcss_pkg::ST_STORE;
          end
        end
      end
      tcss_pkg::ST_FETCH:
      begin
        // Wait for the operand doubleword from main storage.
        if (MEM_ACK)
        begin
          r_d.mem_req = 1'b0;
          r_d.hi_buf = MEM_RDATA[tcss_pkg::DW_W-1:tcss_pkg::WORD_W];
          // Low control byte cleared, so bits 52..63 never reach it. RL9
          r_d.lo_buf = {MEM_RDATA[tcss_pkg::WORD_W-1:8],
            tcss_pkg::CTRL_CLEAR}; // RL11
          r_d.st = tcss_pkg::ST_CLRRUN;
        end
      end
      tcss_pkg::ST_CLRRUN:
      begin
        // Destine the low word with run off to stop the clock. RL11
        wr_lo = 1'b1;
        wdata = r_q.lo_buf;
        r_d.st = tcss_pkg::ST_SENSE;
      end
      tcss_pkg::ST_SENSE:
      begin
        // A run bit still on means the switch refused the stop. RL12
        if (r_q.run || r_q.secure)
        begin
          r_d.cc = tcss_pkg::CC_1; // RL10
          r_d.done = 1'b1;
          r_d.st = tcss_pkg::ST_IDLE;
        end
        else
        begin
          r_d.lo_buf[tcss_pkg::LO_RUN_BIT] = 1'b1; // RL13
          r_d.st = tcss_pkg::ST_LOADH;
        end
      end
      tcss_pkg::ST_LOADH:
      begin
        // High word goes first so the start sees a complete value. RL13
        wr_hi = 1'b1;
        wdata = r_q.hi_buf;
        r_d.st = tcss_pkg::ST_LOADL;
      end
      tcss_pkg::ST_LOADL:
      begin
        // Low word with run on starts the clock at the next pulse. RL13
        wr_lo = 1'b1;
        wdata = r_q.lo_buf;
        r_d.cc = tcss_pkg::CC_0; // RL10
        r_d.done = 1'b1;
        r_d.st = tcss_pkg::ST_IDLE;
      end
      tcss_pkg::ST_STORE:
      begin
        // Hold the store request until storage takes it.
        if (MEM_ACK)
        begin
          r_d.mem_req = 1'b0;
          r_d.mem_we = 1'b0;
          r_d.done = 1'b1;
          r_d.st = tcss_pkg::ST_IDLE;
        end
      end
      default:
      begin
        // An illegal code returns quietly to idle.
        r_d.mem_req = 1'b0;
        r_d.mem_we = 1'b0;
        r_d.st = tcss_pkg::ST_IDLE;
      end
    endcase

    // Manual destinations are taken only while no instruction runs,
    // which keeps the sequencer's stop and start steps atomic.
    if (EXT_WR && (r_q.st == tcss_pkg::ST_IDLE))
    begin
      // A switch byte is copied into every byte of the word. RL2
      wdata = EXT_BYTE_MODE ? {4{EXT_WDATA[7:0]}} : EXT_WDATA;
      wr_hi = (EXT_ADDR == tcss_pkg::EXT_HI_ADDR);
      wr_lo = (EXT_ADDR == tcss_pkg::EXT_LO_ADDR);
    end

    // Advance while running; the sum wraps past all ones. RL19
    if (r_q.run && TICK_1MHZ)
      r_d.cnt = r_q.cnt + tcss_pkg::CNT_ONE; // RL3

    // The high word only loads while the clock is stopped.
    if (wr_hi && !r_q.run)
    begin
      r_d.cnt[tcss_pkg::CNT_W-1:tcss_pkg::LO_CNT_W] = wdata; // RL1
      r_d.hi_loaded = 1'b1;
    end

    // The low word needs the switch; a refusal is remembered so that
    // the read-back after the stop step reports the secure position.
    if (wr_lo)
    begin
      if (!KEY_ENABLE_SET)
        r_d.secure = 1'b1; // RL12
      else if (r_q.run)
      begin
        r_d.secure = 1'b0;
        if (!wdata[tcss_pkg::LO_RUN_BIT])
        begin
          // Stopping also drops the set latch and the load latch.
          r_d.run = 1'b0;
          r_d.set = 1'b0;
          r_d.hi_loaded = 1'b0;
        end
      end
      else
      begin
        r_d.secure = 1'b0;
        r_d.cnt[tcss_pkg::LO_CNT_W-1:0] = wdata[tcss_pkg::WORD_W-1:
          tcss_pkg::LO_CNT_LSB];
        if (wdata[tcss_pkg::LO_RUN_BIT])
        begin
          // Both words loaded: the clock is set and runs. RL18
          r_d.run = 1'b1;
          r_d.set = r_q.hi_loaded;
          r_d.err = r_q.hi_loaded ? 1'b0 : r_q.err;
          r_d.hi_loaded = 1'b0;
        end
      end
    end

    // A counter fault wins over any clear in the same cycle.
    if (CLOCK_ERROR)
    begin
      r_d.err = 1'b1; // RL18
      r_d.set = 1'b0;
    end

    // External readout of either word, zero for any other address.
    if (EXT_RD)
    begin
      r_d.ext_rvalid = 1'b1;
      if (EXT_ADDR == tcss_pkg::EXT_HI_ADDR)
        r_d.ext_rdata = r_q.cnt[tcss_pkg::CNT_W-1:tcss_pkg::LO_CNT_W];
      else if (EXT_ADDR == tcss_pkg::EXT_LO_ADDR)
        r_d.ext_rdata = lo_word;
      else
        r_d.ext_rdata = '0;
    end

    // The indicator follows the new control bits.
    r_d.invalid = ~(r_d.run & r_d.set & ~r_d.err);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on reset zeroes the counter and starts it unset, so the
  // clock serves as elapsed time until software sets it.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      r_q <= '0;
      r_q.st <= tcss_pkg::ST_IDLE;
      r_q.cnt <= tcss_pkg::CNT_RESET;
      r_q.run <= 1'b1;
      r_q.invalid <= 1'b1;
    end
    else if (CE)
      r_q <= r_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a field of the state register.
  assign INSTR_DONE = r_q.done;
  assign INSTR_CC = r_q.cc;
  assign PRIV_CHECK = r_q.priv_chk;
  assign SPEC_CHECK = r_q.spec_chk;
  assign OPER_CHECK = r_q.oper_chk;
  assign MEM_REQ = r_q.mem_req;
  assign MEM_WE = r_q.mem_we;
  assign MEM_ADDR = r_q.mem_addr;
  assign MEM_WDATA = r_q.mem_wdata;
  assign EXT_RDATA = r_q.ext_rdata;
  assign EXT_RVALID = r_q.ext_rvalid;
  assign CLOCK_INVALID = r_q.invalid;

endmodule
